// ===== design/drive_run_consts.vh
// Constants for the run-command and frequency-source control block
//
// Notes on behaviour
// RL1: Over-modulation bit zero allows 13% step-up above source voltage.
// RL2: Frequency source 0 keypad, 1 serial, 2 analog, 3 up/down.
// RL3: Up/down steps once per pulse, ramps while held.
// RL4: Up/down holds frequency while both asserted.
// RL5: Source 4 is pulse frequency over divisor.
// RL6: Command source 0 serial/keypad, 1 terminals/keypad, 2 keypad, 3 terminals.
// RL7: Sources 0, 1 toggle by keypad key; lamp lit when keypad active.
// RL8: Stop bit zero: stop or fault ramps down, then stops.
// RL9: Stop bit one: output off at once, motor coasts.
// RL10: After fault reset, resume only if restart bit is one.
// RL11: Lockout on: run held at power-up ignored until reasserted.
// RL12: Lockout off: run held at power-up starts the drive.
// RL13: Lockout only for run terminals under terminal source.
// RL14: Transition bit zero reverses through zero; one does not.
// RL15: Profile bit zero linear, one S-curve at high speed.
// RL16: Direction inhibit 0 both, 1 no reverse, 2 no forward.
// RL17: Restart after stop waits 0 to 60.00 s.
// RL18: Fan bit zero: fan on at power-up; one: on with run.
// RL19: Dial step 0.01, 0.10, 1.00, 10.00 Hz for codes 0 to 3.
// RL20: Team code 0 A, 1 B, 2 third multi-function input.
// RL21: One team at a time; reset touches selected team only.
// RL22: Team change only while stopped.
// RL23: Out-of-range selection codes rejected; old value kept.
`ifndef DRIVE_RUN_CONSTS_VH
`define DRIVE_RUN_CONSTS_VH

// Register offsets
`define OFS_FREQ_SRC      4'h0
`define OFS_CMD_SRC       4'h1
`define OFS_STOP_CFG      4'h2
`define OFS_DIR_INHIBIT   4'h3
`define OFS_RESTART_WAIT  4'h4
`define OFS_FAN_CFG       4'h5
`define OFS_DIAL_RES      4'h6
`define OFS_TEAM_SEL      4'h7
`define OFS_MISC_CFG      4'h8
`define OFS_PULSE_DIV     4'h9
`define OFS_START_FREQ    4'ha
`define OFS_LOWER_LIMIT   4'hb
`define OFS_KEY_FREQ      4'hc
`define OFS_CONTROL       4'hd
`define OFS_STATUS        4'he
`define OFS_MASTER_FREQ   4'hf

// Stop and lockout field positions
`define BIT_COAST         0
`define BIT_RESTART       1
`define BIT_LOCKOUT_DIS   2
`define BIT_NO_ZERO_PASS  3
`define BIT_SCURVE        4
// Misc config: over-modulation selection bit
`define BIT_OVERMOD_OFF   1
// Control register bits: pulses in bits 0 to 6, serial run and reverse levels in bits 7 and 8
`define BIT_CTL_KEY_RUN   0
`define BIT_CTL_KEY_STOP  1
`define BIT_CTL_PU_KEY    2
`define BIT_CTL_KEY_FWD   3
`define BIT_CTL_KEY_REV   4
`define BIT_CTL_FAULT_RST 5
`define BIT_CTL_PAR_RST   6
`define BIT_CTL_SER_RUN   7
`define BIT_CTL_SER_REV   8

// Reset values
`define RST_FREQ_SRC      3'h0
`define RST_CMD_SRC       2'h0
`define RST_STOP_CFG      5'h00
`define RST_DIR_INHIBIT   2'h0
`define RST_RESTART_WAIT  13'h0000
`define RST_FAN_CFG       1'h0
`define RST_DIAL_RES      2'h1
`define RST_TEAM_SEL      2'h0
`define RST_PULSE_DIV     16'h0001
`define RST_START_FREQ    16'h0032

// Timing: wait time in 10 ms units, step-up limit in percent
`define WAIT_UNIT_NS      10000000
`define OVERMOD_PCT       8'h0d
`define MAX_WAIT_CODE     13'h1770
`define MAX_FREQ_SRC      3'h4
`endif

// ===== design/drive_run_control.v
// Run-command and frequency-source control of a compact motor drive
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
`include "drive_run_consts.vh"

module drive_run_control #(
    parameter CLK_NS      = 25,
    parameter RAMP_DIV    = 40000,
    parameter GATE_CYCLES = 40000000,
    parameter FW          = 16
) (
    // Clock and reset
    input  wire          clk_sys,
    input  wire          arst_n,
    // Register port
    input  wire [3:0]    regAddr,
    input  wire [15:0]   regWrData,
    input  wire          regWr,
    input  wire          regRd,
    output reg  [15:0]   regRdData,
    // Terminals and pins
    input  wire          forwardRunTerminal,
    input  wire          reverseRunTerminal,
    input  wire          upTerminal,
    input  wire          downTerminal,
    input  wire          thirdMultiFunctionInput,
    input  wire          pulseInput,
    input  wire          extFault,
    input  wire          faultActive,
    input  wire          dialStepUp,
    input  wire          dialStepDown,
    // Frequency sources from other logic
    input  wire [FW-1:0] serialFreq,
    input  wire [FW-1:0] analogFreq,
    input  wire          rampDone,
    // Outputs
    output reg  [FW-1:0] masterFreq,
    output reg           runActive,
    output reg           reverseDir,
    output reg           outputEnable,
    output reg           rampStop,
    output reg           passZero,
    output reg           sCurve,
    output reg           overmodAllowed,
    output reg  [7:0]    stepUpLimitPct,
    output reg           keypadLamp,
    output reg           fanOn,
    output reg           teamB,
    output reg           teamResetA,
    output reg           teamResetB
);

    localparam [FW-1:0] FREQ_MAX = {FW{1'b1}};
    localparam WAIT_CYC = `WAIT_UNIT_NS / CLK_NS;

    //------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------
    reg [10:0] syncA_ff;
    reg [10:0] syncB_ff;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            syncA_ff <= 11'h000;
            syncB_ff <= 11'h000;
        end else begin
            syncA_ff <= {pulseInput, dialStepDown, dialStepUp, faultActive, extFault,
                         thirdMultiFunctionInput, downTerminal, upTerminal,
                         reverseRunTerminal, forwardRunTerminal, 1'b1};
            syncB_ff <= syncA_ff;
        end
    end
    wire fwdS   = syncB_ff[1];
    wire revS   = syncB_ff[2];
    wire upS    = syncB_ff[3];
    wire dnS    = syncB_ff[4];
    wire mi3S   = syncB_ff[5];
    wire extFlt = syncB_ff[6];
    wire fltS   = syncB_ff[7];
    wire dialUp = syncB_ff[8];
    wire dialDn = syncB_ff[9];
    wire pulseS = syncB_ff[10];
    reg  [10:0] prev_ff;
    wire [10:0] rise = syncB_ff & ~prev_ff;

    //------------------------------------------------------------
    // Configuration registers
    //------------------------------------------------------------
    reg [2:0]    freqSrc_ff;
    reg [1:0]    cmdSrc_ff;
    reg [4:0]    stopCfg_ff;
    reg [1:0]    dirInhibit_ff;
    reg [12:0]   restartWait_ff;
    reg          fanCfg_ff;
    reg [1:0]    dialRes_ff;
    reg [1:0]    teamSel_ff;
    reg          miscOvermodOff_ff;
    reg [15:0]   pulseDiv_ff;
    reg [FW-1:0] startFreq_ff;
    reg [FW-1:0] lowerLimit_ff;
    wire [8:0]   ctl = (regWr && regAddr == `OFS_CONTROL) ? regWrData[8:0] : 9'h000;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            freqSrc_ff        <= `RST_FREQ_SRC;
            cmdSrc_ff         <= `RST_CMD_SRC;
            stopCfg_ff        <= `RST_STOP_CFG;
            dirInhibit_ff     <= `RST_DIR_INHIBIT;
            restartWait_ff    <= `RST_RESTART_WAIT;
            fanCfg_ff         <= `RST_FAN_CFG;
            dialRes_ff        <= `RST_DIAL_RES;
            teamSel_ff        <= `RST_TEAM_SEL;
            miscOvermodOff_ff <= 1'b0;
            pulseDiv_ff       <= `RST_PULSE_DIV;
            startFreq_ff      <= `RST_START_FREQ;
            lowerLimit_ff     <= {FW{1'b0}};
        end else if (regWr) begin
            case (regAddr)
                `OFS_FREQ_SRC:
                    if (regWrData[2:0] <= `MAX_FREQ_SRC)          // [RL23]
                        freqSrc_ff <= regWrData[2:0];
                `OFS_CMD_SRC:      cmdSrc_ff <= regWrData[1:0];
                `OFS_STOP_CFG:     stopCfg_ff <= regWrData[4:0];
                `OFS_DIR_INHIBIT:
                    if (regWrData[1:0] != 2'h3)                   // [RL23]
                        dirInhibit_ff <= regWrData[1:0];
                `OFS_RESTART_WAIT:
                    if (regWrData[12:0] <= `MAX_WAIT_CODE)        // [RL23]
                        restartWait_ff <= regWrData[12:0];
                `OFS_FAN_CFG:      fanCfg_ff <= regWrData[0];
                `OFS_DIAL_RES:     dialRes_ff <= regWrData[1:0];
                `OFS_TEAM_SEL:
                    if (regWrData[1:0] != 2'h3)                   // [RL23]
                        teamSel_ff <= regWrData[1:0];
                `OFS_MISC_CFG:     miscOvermodOff_ff <= regWrData[`BIT_OVERMOD_OFF];
                `OFS_PULSE_DIV:
                    if (regWrData != 16'h0000)                    // [RL23]
                        pulseDiv_ff <= regWrData;
                `OFS_START_FREQ:   startFreq_ff <= regWrData[FW-1:0];
                `OFS_LOWER_LIMIT:  lowerLimit_ff <= regWrData[FW-1:0];
                default: ;
            endcase
        end
    end

    //------------------------------------------------------------
    // Command source and keypad toggle
    //------------------------------------------------------------
    reg keypadSel_ff;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            keypadSel_ff <= 1'b0;
        else if (cmdSrc_ff[1])
            keypadSel_ff <= (cmdSrc_ff == 2'h2);                  // [RL6]
        else if (ctl[`BIT_CTL_PU_KEY])
            keypadSel_ff <= ~keypadSel_ff;                        // [RL7]
    end
    wire useTerm   = (cmdSrc_ff == 2'h3) || (cmdSrc_ff == 2'h1 && !keypadSel_ff);
    wire useSerial = (cmdSrc_ff == 2'h0) && !keypadSel_ff;

    //------------------------------------------------------------
    // Run request and line start lockout
    //------------------------------------------------------------
    reg lockout_ff;
    reg keyRun_ff;
    reg keyRev_ff;
    reg serRun_ff;
    reg serRev_ff;
    reg firstCycle_ff;
    wire termAny = fwdS | revS;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            lockout_ff    <= 1'b1;
            firstCycle_ff <= 1'b1;
            keyRun_ff     <= 1'b0;
            keyRev_ff     <= 1'b0;
            serRun_ff     <= 1'b0;
            serRev_ff     <= 1'b0;
        end else begin
            // Synchronisers need two edges; decide lockout after they settle
            if (firstCycle_ff && prev_ff[0]) begin
                firstCycle_ff <= 1'b0;
                lockout_ff    <= !stopCfg_ff[`BIT_LOCKOUT_DIS] && termAny; // [RL11] [RL12]
            end else if (!termAny)
                lockout_ff <= 1'b0;                               // [RL11]
            if (ctl[`BIT_CTL_KEY_RUN])
                keyRun_ff <= 1'b1;
            else if (ctl[`BIT_CTL_KEY_STOP])
                keyRun_ff <= 1'b0;
            if (ctl[`BIT_CTL_KEY_FWD])
                keyRev_ff <= 1'b0;
            else if (ctl[`BIT_CTL_KEY_REV])
                keyRev_ff <= 1'b1;
            if (regWr && regAddr == `OFS_CONTROL) begin
                serRun_ff <= regWrData[`BIT_CTL_SER_RUN];
                serRev_ff <= regWrData[`BIT_CTL_SER_REV];
            end
        end
    end
    // Lockout only masks the run terminals in terminal mode
    wire termRun = termAny && !(lockout_ff || firstCycle_ff);     // [RL13]
    wire reqRun  = useTerm ? termRun : (useSerial ? serRun_ff : keyRun_ff);
    wire reqRev  = useTerm ? (revS && !fwdS) : (useSerial ? serRev_ff : keyRev_ff);
    wire dirOk   = reqRev ? (dirInhibit_ff != 2'h1) : (dirInhibit_ff != 2'h2); // [RL16]

    //------------------------------------------------------------
    // Run state machine
    //------------------------------------------------------------
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_RUN  = 5'h02;
    localparam [4:0] ST_DECEL = 5'h04;
    localparam [4:0] ST_WAIT = 5'h08;
    localparam [4:0] ST_FAULT = 5'h10;
    reg [4:0]  state_ff;
    reg [4:0]  nxt_state;
    reg [31:0] waitCnt_ff;
    reg        wasRunning_ff;
    wire       waitDone = (waitCnt_ff == 32'h0);
    wire       stopReq  = !reqRun || !dirOk || extFlt;

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE:
                if (fltS)
                    nxt_state = ST_FAULT;
                else if (reqRun && dirOk && !extFlt)
                    nxt_state = ST_RUN;
            ST_RUN:
                if (fltS)
                    nxt_state = ST_FAULT;
                else if (stopReq)
                    nxt_state = stopCfg_ff[`BIT_COAST] ? ST_WAIT : ST_DECEL; // [RL8] [RL9]
            ST_DECEL:
                if (fltS)
                    nxt_state = ST_FAULT;
                else if (rampDone)
                    nxt_state = ST_WAIT;                          // [RL8]
            ST_WAIT:
                if (waitDone)
                    nxt_state = ST_IDLE;                          // [RL17]
            ST_FAULT:
                if (!fltS && ctl[`BIT_CTL_FAULT_RST])
                    nxt_state = (stopCfg_ff[`BIT_RESTART] && wasRunning_ff) ?
                                ST_RUN : ST_WAIT;                 // [RL10]
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_ff      <= ST_IDLE;
            waitCnt_ff    <= 32'h0;
            wasRunning_ff <= 1'b0;
            prev_ff       <= 11'h000;
        end else begin
            state_ff <= nxt_state;
            prev_ff  <= syncB_ff;
            if (state_ff != ST_FAULT)
                wasRunning_ff <= (state_ff == ST_RUN);
            if (nxt_state == ST_WAIT && state_ff != ST_WAIT)
                waitCnt_ff <= restartWait_ff * WAIT_CYC;          // [RL17]
            else if (!waitDone)
                waitCnt_ff <= waitCnt_ff - 32'h1;
        end
    end

    //------------------------------------------------------------
    // Master frequency selection
    //------------------------------------------------------------
    reg  [FW-1:0] keyFreq_ff;
    reg  [FW-1:0] upDnFreq_ff;
    reg  [FW-1:0] pulseFreq_ff;
    reg  [31:0]   rampCnt_ff;
    reg  [31:0]   gateCnt_ff;
    reg  [FW-1:0] pulseCnt_ff;
    wire          rampTick = (rampCnt_ff == 32'h0);
    wire          gateTick = (gateCnt_ff == 32'h0);

    function [FW-1:0] satStep;
        input [FW-1:0] val;
        input [FW-1:0] step;
        input          down;
        begin
            if (down)
                satStep = (val > step) ? val - step : {FW{1'b0}};
            else
                satStep = (FREQ_MAX - val > step) ? val + step : FREQ_MAX;
        end
    endfunction

    function [FW-1:0] dialStep;
        input [1:0] res;
        begin
            case (res)
                2'h0:    dialStep = 1;                            // [RL19]
                2'h1:    dialStep = 10;
                2'h2:    dialStep = 100;
                default: dialStep = 1000;
            endcase
        end
    endfunction

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            keyFreq_ff   <= {FW{1'b0}};
            upDnFreq_ff  <= {FW{1'b0}};
            pulseFreq_ff <= {FW{1'b0}};
            rampCnt_ff   <= 32'h0;
            gateCnt_ff   <= 32'h0;
            pulseCnt_ff  <= {FW{1'b0}};
        end else begin
            rampCnt_ff <= rampTick ? RAMP_DIV - 1 : rampCnt_ff - 32'h1;
            if (regWr && regAddr == `OFS_KEY_FREQ)
                keyFreq_ff <= regWrData[FW-1:0];
            else if (rise[8] && !dialDn)
                keyFreq_ff <= satStep(keyFreq_ff, dialStep(dialRes_ff), 1'b0); // [RL19]
            else if (rise[9] && !dialUp)
                keyFreq_ff <= satStep(keyFreq_ff, dialStep(dialRes_ff), 1'b1); // [RL19]
            // Both asserted holds; edge steps once, held level ramps
            if (upS && dnS)
                upDnFreq_ff <= upDnFreq_ff;                       // [RL4]
            else if (upS && (rise[3] || rampTick))
                upDnFreq_ff <= satStep(upDnFreq_ff, 1, 1'b0);     // [RL3]
            else if (dnS && (rise[4] || rampTick))
                upDnFreq_ff <= satStep(upDnFreq_ff, 1, 1'b1);     // [RL3]
            // Pulse count over a one-second gate gives frequency in Hz
            if (gateTick) begin
                gateCnt_ff   <= GATE_CYCLES - 1;
                pulseCnt_ff  <= {FW{1'b0}};
                pulseFreq_ff <= pulseCnt_ff / pulseDiv_ff;        // [RL5]
            end else begin
                gateCnt_ff <= gateCnt_ff - 32'h1;
                if (rise[10])
                    pulseCnt_ff <= satStep(pulseCnt_ff, 1, 1'b0);
            end
        end
    end

    reg [FW-1:0] nxt_masterFreq;
    always @* begin
        case (freqSrc_ff)
            3'h0:    nxt_masterFreq = keyFreq_ff;                 // [RL2]
            3'h1:    nxt_masterFreq = serialFreq;
            3'h2:    nxt_masterFreq = analogFreq;
            3'h3:    nxt_masterFreq = upDnFreq_ff;
            default: nxt_masterFreq = pulseFreq_ff;               // [RL5]
        endcase
    end

    //------------------------------------------------------------
    // Team selection, applied only while stopped
    //------------------------------------------------------------
    wire stopped  = (state_ff == ST_IDLE);
    wire teamWant = (teamSel_ff == 2'h2) ? mi3S : teamSel_ff[0]; // [RL20]

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            masterFreq     <= {FW{1'b0}};
            runActive      <= 1'b0;
            reverseDir     <= 1'b0;
            outputEnable   <= 1'b0;
            rampStop       <= 1'b0;
            passZero       <= 1'b1;
            sCurve         <= 1'b0;
            overmodAllowed <= 1'b0;
            stepUpLimitPct <= 8'h00;
            keypadLamp     <= 1'b0;
            fanOn          <= 1'b0;
            teamB          <= 1'b0;
            teamResetA     <= 1'b0;
            teamResetB     <= 1'b0;
        end else begin
            masterFreq   <= nxt_masterFreq;
            runActive    <= (nxt_state == ST_RUN);
            if (nxt_state == ST_RUN)
                reverseDir <= reqRev;
            outputEnable <= (nxt_state == ST_RUN) || (nxt_state == ST_DECEL); // [RL9]
            rampStop     <= (nxt_state == ST_DECEL);              // [RL8]
            passZero     <= !stopCfg_ff[`BIT_NO_ZERO_PASS];       // [RL14]
            sCurve       <= stopCfg_ff[`BIT_SCURVE];              // [RL15]
            overmodAllowed <= !miscOvermodOff_ff;                 // [RL1]
            stepUpLimitPct <= miscOvermodOff_ff ? 8'h00 : `OVERMOD_PCT; // [RL1]
            keypadLamp   <= (cmdSrc_ff == 2'h2) ||
                            (!cmdSrc_ff[1] && keypadSel_ff);      // [RL7]
            fanOn        <= !fanCfg_ff || (state_ff != ST_IDLE) || reqRun; // [RL18]
            if (stopped)
                teamB <= teamWant;                                // [RL22]
            teamResetA   <= ctl[`BIT_CTL_PAR_RST] && !teamB;      // [RL21]
            teamResetB   <= ctl[`BIT_CTL_PAR_RST] && teamB;       // [RL21]
        end
    end

    //------------------------------------------------------------
    // Register read
    //------------------------------------------------------------
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n)
            regRdData <= 16'h0000;
        else if (regRd) begin
            case (regAddr)
                `OFS_FREQ_SRC:     regRdData <= {13'h0, freqSrc_ff};
                `OFS_CMD_SRC:      regRdData <= {14'h0, cmdSrc_ff};
                `OFS_STOP_CFG:     regRdData <= {11'h0, stopCfg_ff};
                `OFS_DIR_INHIBIT:  regRdData <= {14'h0, dirInhibit_ff};
                `OFS_RESTART_WAIT: regRdData <= {3'h0, restartWait_ff};
                `OFS_FAN_CFG:      regRdData <= {15'h0, fanCfg_ff};
                `OFS_DIAL_RES:     regRdData <= {14'h0, dialRes_ff};
                `OFS_TEAM_SEL:     regRdData <= {14'h0, teamSel_ff};
                `OFS_MISC_CFG:     regRdData <= {14'h0, miscOvermodOff_ff, 1'b0};
                `OFS_PULSE_DIV:    regRdData <= pulseDiv_ff;
                `OFS_START_FREQ:   regRdData <= startFreq_ff;
                `OFS_LOWER_LIMIT:  regRdData <= lowerLimit_ff;
                `OFS_KEY_FREQ:     regRdData <= keyFreq_ff;
                `OFS_STATUS:       regRdData <= {6'h0, lockout_ff, teamB, keypadLamp,
                                                 fanOn, reverseDir, state_ff};
                `OFS_MASTER_FREQ:  regRdData <= masterFreq;
                default:           regRdData <= 16'h0000;
            endcase
        end else
            regRdData <= 16'h0000;
    end

endmodule

// ===== testbench/drive_far_side.sv
// Far-side model: serial host, analog source, ramp generator, pulse source
`timescale 1ns/10ps
module drive_far_side (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        arst_n,
    // Device side
    input  wire        rampStop,
    output wire [15:0] serialFreq,
    output wire [15:0] analogFreq,
    output reg         rampDone,
    output reg         pulseInput
);
    reg [3:0] rampCnt_ff;
    assign serialFreq = 16'h0456;
    assign analogFreq = 16'h0789;
    // Deceleration lasts ten cycles so the stop state can be seen
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rampCnt_ff <= 4'h0;
            rampDone   <= 1'b0;
            pulseInput <= 1'b0;
        end else begin
            rampCnt_ff <= rampStop ? rampCnt_ff + 4'h1 : 4'h0;
            rampDone   <= (rampCnt_ff == 4'h8);
            pulseInput <= ~pulseInput;
        end
    end
endmodule

// ===== testbench/drive_run_control_sva.sv
// Port assertions for the run-command control block
`timescale 1ns/10ps
module drive_run_control_sva (
    input wire       clk_sys,
    input wire       arst_n,
    input wire       runActive,
    input wire       rampStop,
    input wire       outputEnable,
    input wire       overmodAllowed,
    input wire [7:0] stepUpLimitPct,
    input wire       fanOn,
    input wire       teamB,
    input wire       teamResetA,
    input wire       teamResetB
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_step_limit: assert property ($stable(overmodAllowed)
        |-> stepUpLimitPct == (overmodAllowed ? 8'h0d : 8'h00)) else $error("step-up");
    a_decel_norun: assert property (rampStop |-> !runActive) else $error("decel run");
    a_idle_off: assert property ((!runActive && !rampStop) [*2] |-> !outputEnable)
        else $error("idle output");
    a_run_on: assert property (runActive [*2] |-> outputEnable) else $error("run off");
    a_fan_run: assert property (runActive [*2] |-> fanOn) else $error("fan off");
    a_team_hold: assert property (runActive [*2] |-> $stable(teamB)) else $error("team");
    a_reset_pulse: assert property ((teamResetA || teamResetB)
        |=> !(teamResetA || teamResetB)) else $error("reset long");
    a_reset_excl: assert property (!(teamResetA && teamResetB)) else $error("both");
    a_reset_sel: assert property ((teamResetA || teamResetB) |-> teamResetB == teamB)
        else $error("reset team");
endmodule
bind drive_run_control drive_run_control_sva chk (.*);

// ===== testbench/tb.sv
// Self-checking bench for the run-command control block
`timescale 1ns/10ps
module tb;
    reg         clk_sys   = 1'b0;
    reg         arst_n    = 1'b0;
    reg  [3:0]  regAddr   = 4'h0;
    reg  [15:0] regWrData = 16'h0000;
    reg         regWr = 1'b0, regRd = 1'b0, fwdRun = 1'b0, revRun = 1'b0;
    reg         mfIn3 = 1'b0, dialUp = 1'b0, upIn = 1'b0, dnIn = 1'b0;
    reg  [15:0] step;
    wire [15:0] regRdData, serialFreq, analogFreq;
    wire [7:0]  stepUpLimitPct;
    wire        pulseInput, rampDone, runActive, outputEnable, rampStop;
    wire        overmodAllowed, keypadLamp, fanOn, teamB;
    integer     err_total = 0, compares = 0, i;
    drive_far_side far (.*);
    // Short ramp and gate counts keep the run brief
    drive_run_control #(.RAMP_DIV(4), .GATE_CYCLES(100)) uut (.*, .forwardRunTerminal(fwdRun),
        .reverseRunTerminal(revRun), .upTerminal(upIn), .downTerminal(dnIn),
        .thirdMultiFunctionInput(mfIn3), .extFault(1'b0), .faultActive(1'b0),
        .dialStepUp(dialUp), .dialStepDown(1'b0), .masterFreq(), .reverseDir(),
        .passZero(), .sCurve(), .teamResetA(), .teamResetB());
    initial forever #12.5 clk_sys = ~clk_sys;
    // ----------------------------------------
    // Bus tasks and comparison
    // ----------------------------------------
    task end_sim;
        begin
            $display("Compares %0d, mismatches %0d", compares, err_total);
            if (err_total == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task cmp(input [15:0] got, input [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge clk_sys);
            regWr     <= 1'b1;
            regAddr   <= a;
            regWrData <= d;
            @(posedge clk_sys);
            regWr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [15:0] exp);
        begin
            @(posedge clk_sys);
            regRd   <= 1'b1;
            regAddr <= a;
            @(posedge clk_sys);
            regRd <= 1'b0;
            #1 cmp(regRdData, exp);
        end
    endtask
    task cb(input got, input exp);
        cmp({15'h0000, got}, {15'h0000, exp});
    endtask
    // Bounded wait; a timeout ends the run
    task wait_oe(input lvl);
        integer n;
        begin
            for (n = 0; n < 30 && outputEnable !== lvl; n = n + 1)
                @(posedge clk_sys) #1;
            cb(outputEnable, lvl);
            if (outputEnable !== lvl)
                end_sim;
        end
    endtask
    task settle;
        begin
            repeat (6) @(posedge clk_sys);
            #1;
        end
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(4'h6, 16'h0001);
        rd(4'ha, 16'h0032);
        wr(4'hc, 16'h0100);
        rd(4'hf, 16'h0100);
        wr(4'h0, 16'h0001);
        rd(4'hf, 16'h0456);
        wr(4'h0, 16'h0002);
        rd(4'hf, 16'h0789);
        wr(4'h0, 16'h0005);
        rd(4'h0, 16'h0002);
        wr(4'h3, 16'h0003);
        rd(4'h3, 16'h0000);
        wr(4'h0, 16'h0003);
        upIn <= 1'b1;
        dnIn <= 1'b1;
        settle;
        rd(4'hf, 16'h0000);
        upIn <= 1'b0;
        dnIn <= 1'b0;
        $display("Test sources done");
        step = 16'h0001;
        for (i = 0; i < 4; i = i + 1) begin
            wr(4'h6, i[15:0]);
            wr(4'hc, 16'h0100);
            dialUp <= 1'b1;
            repeat (4) @(posedge clk_sys);
            dialUp <= 1'b0;
            repeat (4) @(posedge clk_sys);
            rd(4'hc, 16'h0100 + step);
            step = step * 16'h000a;
        end
        wr(4'h8, 16'h0002);
        settle;
        cmp({8'h00, stepUpLimitPct}, 16'h0000);
        wr(4'h8, 16'h0000);
        settle;
        cmp({8'h00, stepUpLimitPct}, 16'h000d);
        wr(4'h7, 16'h0002);
        mfIn3 <= 1'b1;
        settle;
        cb(teamB, 1'b1);
        wr(4'hd, 16'h0040);
        wr(4'h7, 16'h0000);
        settle;
        cb(teamB, 1'b0);
        wr(4'hd, 16'h0040);
        wr(4'h5, 16'h0001);
        settle;
        cb(fanOn, 1'b0);
        $display("Test settings done");
        wr(4'h1, 16'h0003);
        wr(4'h3, 16'h0001);
        wr(4'h2, 16'h0001);
        revRun <= 1'b1;
        settle;
        cb(runActive, 1'b0);
        cb(keypadLamp, 1'b0);
        revRun <= 1'b0;
        fwdRun <= 1'b1;
        wait_oe(1'b1);
        wr(4'h7, 16'h0001);
        settle;
        cb(teamB, 1'b0);
        fwdRun <= 1'b0;
        wait_oe(1'b0);
        cb(rampStop, 1'b0);
        settle;
        cb(teamB, 1'b1);
        wr(4'h2, 16'h0000);
        fwdRun <= 1'b1;
        wait_oe(1'b1);
        fwdRun <= 1'b0;
        settle;
        cb(rampStop, 1'b1);
        wait_oe(1'b0);
        wr(4'h1, 16'h0001);
        wr(4'hd, 16'h0004);
        settle;
        cb(keypadLamp, 1'b1);
        wr(4'h1, 16'h0002);
        wr(4'hd, 16'h0001);
        wait_oe(1'b1);
        $display("Test run and stop done");
        end_sim;
    end
endmodule
